// [common/lsr_map.vh]
// Register map, field layout and reset values of the linefeed setpoint bank
`ifndef LSR_MAP_VH
`define LSR_MAP_VH

// Bus widths
`define LSR_ADDR_W 12
`define LSR_IDX_W 10
`define LSR_DATA_W 32

// Register indices; byte address is four times the index
`define LSR_IDX_FEED 10'h047
`define LSR_IDX_ONHOOK 10'h048
`define LSR_IDX_CMODE 10'h049
`define LSR_IDX_HBAT 10'h04A
`define LSR_IDX_LBAT 10'h04B
`define LSR_IDX_PTR 10'h04C
`define LSR_IDX_PWR 10'h04D

// Field positions
`define LSR_FEED_MSB 2
`define LSR_POL_BIT 6
`define LSR_CODE_MSB 5
`define LSR_PTR_MSB 2
`define LSR_PWR_MSB 7

// Field reset values
`define LSR_RST_FEED 3'h0
`define LSR_RST_POL 1'h0
`define LSR_RST_VOC 6'h20
`define LSR_RST_VCM 6'h02
`define LSR_RST_HBAT 6'h32
`define LSR_RST_LBAT 6'h10
`define LSR_RST_PTR 3'h0
`define LSR_RST_PWR 8'h00

// Pointer codes
`define LSR_PTR_Q1 3'h0
`define LSR_PTR_Q3 3'h2
`define LSR_PTR_Q4 3'h3
`define LSR_PTR_Q6 3'h5
`define LSR_PTR_COUNT 6

// Bus responses
`define LSR_RESP_OKAY 2'h0
`define LSR_RESP_SLVERR 2'h2

`endif

// [core/lsr_power_mux.v]
// Transistor power sampling and pointer-driven selection
`timescale 1ns/1ps
`default_nettype none
`include "lsr_map.vh"

module lsr_power_mux (
    input wire clk,
    input wire rst,
    input wire [47:0] power_in,
    input wire [2:0] sel,
    output reg [7:0] reading,
    output reg fine_scale
);

    reg [47:0] sync_a;
    reg [47:0] sync_b;
    wire [7:0] lane [0:5];

    // Lanes settle slowly, so a two-stage sample is enough; a byte caught
    // mid-change may read one step off for a single cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 48'h000000000000;
            sync_b <= 48'h000000000000;
        end else begin
            sync_a <= power_in;
            sync_b <= sync_a;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `LSR_PTR_COUNT; g = g + 1) begin : g_lane
            assign lane[g] = sync_b[g*8+7:g*8];
        end
    endgenerate

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reading <= `LSR_RST_PWR;
            fine_scale <= 1'b0;
        end else begin
            if (sel > `LSR_PTR_Q6) begin
                reading <= `LSR_RST_PWR;
            end else begin
                reading <= lane[sel];
            end
            fine_scale <= (sel == `LSR_PTR_Q3) || (sel == `LSR_PTR_Q4);
        end
    end

endmodule
`default_nettype wire

// [core/lsr_setpoint_regs.v]
// Linefeed setpoint register bank behind an AXI4-Lite slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_map.vh"

module lsr_setpoint_regs (
    input wire SYS_CLK,
    input wire RST,
    input wire [11:0] AWADDR,
    input wire [2:0] AWPROT,
    input wire AWVALID,
    output reg AWREADY,
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    input wire WVALID,
    output reg WREADY,
    output reg [1:0] BRESP,
    output reg BVALID,
    input wire BREADY,
    input wire [11:0] ARADDR,
    input wire [2:0] ARPROT,
    input wire ARVALID,
    output reg ARREADY,
    output reg [31:0] RDATA,
    output reg [1:0] RRESP,
    output reg RVALID,
    input wire RREADY,
    input wire [47:0] TRANSISTOR_POWER_IN,
    output reg [2:0] FEED_CURRENT_CODE,
    output reg ONHOOK_POLARITY_SEL,
    output reg [5:0] ONHOOK_VOLTAGE_CODE,
    output reg [5:0] COMMON_MODE_CODE,
    output reg [5:0] HIGH_BATTERY_CODE,
    output reg [5:0] LOW_BATTERY_CODE,
    output reg [2:0] TRANSISTOR_POWER_POINTER,
    output wire [7:0] TRANSISTOR_POWER_READING,
    output wire POWER_FINE_SCALE
);

    // Protection bits carry no meaning for this bank
    wire prot_unused;
    assign prot_unused = ^{AWPROT, ARPROT};

    reg started;
    reg have_aw;
    reg have_w;
    reg [9:0] wr_idx;
    reg [7:0] wr_byte;
    reg wr_lane0;
    reg [31:0] rd_word;
    reg rd_known;
    reg [2:0] next_feed;
    reg next_pol;
    reg [5:0] next_voc;
    reg [5:0] next_vcm;
    reg [5:0] next_hbat;
    reg [5:0] next_lbat;
    reg [2:0] next_ptr;
    wire write_now;
    wire write_known;
    wire write_store;
    wire [7:0] power_reading;
    wire power_fine;

    // Index hit test used by the write decoder; the read decoder uses a case on the index
    function hit;
        input [9:0] idx;
        input [9:0] reg_idx;
        begin
            hit = (idx == reg_idx);
        end
    endfunction

    // Writable registers; the power reading is read-only
    function writable;
        input [9:0] idx;
        begin
            writable = hit(idx, `LSR_IDX_FEED) || hit(idx, `LSR_IDX_ONHOOK)
                || hit(idx, `LSR_IDX_CMODE) || hit(idx, `LSR_IDX_HBAT)
                || hit(idx, `LSR_IDX_LBAT) || hit(idx, `LSR_IDX_PTR);
        end
    endfunction

    lsr_power_mux u_power_mux (
        .clk(SYS_CLK),
        .rst(RST),
        .power_in(TRANSISTOR_POWER_IN),
        .sel(TRANSISTOR_POWER_POINTER),
        .reading(power_reading),
        .fine_scale(power_fine)
    );

    // Both come straight from flops inside the sampler
    assign TRANSISTOR_POWER_READING = power_reading;
    assign POWER_FINE_SCALE = power_fine;

    // Write commits once address and data are both held
    assign write_now = have_aw && have_w && !BVALID;
    assign write_known = writable(wr_idx);
    // Only byte lane 0 carries register bits
    assign write_store = write_now && write_known && wr_lane0;

    // Ready flags rise at the first edge after reset leaves, so a request
    // held through reset is not taken while the bank is still settling
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    // Write address channel; refused until the response is taken,
    // and the low two address bits are dropped, so byte offsets alias
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            AWREADY <= 1'b0;
            have_aw <= 1'b0;
            wr_idx <= 10'h000;
        end else begin
            if (!started) begin
                AWREADY <= 1'b1;
            end
            if (AWVALID && AWREADY) begin
                have_aw <= 1'b1;
                wr_idx <= AWADDR[11:2];
                AWREADY <= 1'b0;
            end
            if (write_now) begin
                have_aw <= 1'b0;
            end
            if (BVALID && BREADY) begin
                AWREADY <= 1'b1;
            end
        end
    end

    // Write data channel; only byte lane 0 is kept, the other strobes
    // are accepted and dropped
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            WREADY <= 1'b0;
            have_w <= 1'b0;
            wr_byte <= 8'h00;
            wr_lane0 <= 1'b0;
        end else begin
            if (!started) begin
                WREADY <= 1'b1;
            end
            if (WVALID && WREADY) begin
                have_w <= 1'b1;
                wr_byte <= WDATA[7:0];
                wr_lane0 <= WSTRB[0];
                WREADY <= 1'b0;
            end
            if (write_now) begin
                have_w <= 1'b0;
            end
            if (BVALID && BREADY) begin
                WREADY <= 1'b1;
            end
        end
    end

    // Write response, raised at the edge that stores the fields;
    // a write to an unknown index is answered but stores nothing
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            BVALID <= 1'b0;
            BRESP <= `LSR_RESP_OKAY;
        end else begin
            if (write_now) begin
                BVALID <= 1'b1;
                BRESP <= write_known ? `LSR_RESP_OKAY : `LSR_RESP_SLVERR;
            end
            if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // Next field values from a committed write
    always @* begin
        next_feed = FEED_CURRENT_CODE;
        next_pol = ONHOOK_POLARITY_SEL;
        next_voc = ONHOOK_VOLTAGE_CODE;
        next_vcm = COMMON_MODE_CODE;
        next_hbat = HIGH_BATTERY_CODE;
        next_lbat = LOW_BATTERY_CODE;
        next_ptr = TRANSISTOR_POWER_POINTER;
        if (write_store) begin
            if (hit(wr_idx, `LSR_IDX_FEED)) begin
                next_feed = wr_byte[`LSR_FEED_MSB:0];
            end
            if (hit(wr_idx, `LSR_IDX_ONHOOK)) begin
                next_pol = wr_byte[`LSR_POL_BIT];
                next_voc = wr_byte[`LSR_CODE_MSB:0];
            end
            if (hit(wr_idx, `LSR_IDX_CMODE)) begin
                next_vcm = wr_byte[`LSR_CODE_MSB:0];
            end
            if (hit(wr_idx, `LSR_IDX_HBAT)) begin
                next_hbat = wr_byte[`LSR_CODE_MSB:0];
            end
            if (hit(wr_idx, `LSR_IDX_LBAT)) begin
                next_lbat = wr_byte[`LSR_CODE_MSB:0];
            end
            if (hit(wr_idx, `LSR_IDX_PTR)) begin
                next_ptr = wr_byte[`LSR_PTR_MSB:0];
            end
        end
    end

    // Field storage; reserved bits have no flops, so writes to them vanish
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            FEED_CURRENT_CODE <= `LSR_RST_FEED;
            ONHOOK_POLARITY_SEL <= `LSR_RST_POL;
            ONHOOK_VOLTAGE_CODE <= `LSR_RST_VOC;
            COMMON_MODE_CODE <= `LSR_RST_VCM;
            HIGH_BATTERY_CODE <= `LSR_RST_HBAT;
            LOW_BATTERY_CODE <= `LSR_RST_LBAT;
            TRANSISTOR_POWER_POINTER <= `LSR_RST_PTR;
        end else begin
            FEED_CURRENT_CODE <= next_feed;
            ONHOOK_POLARITY_SEL <= next_pol;
            ONHOOK_VOLTAGE_CODE <= next_voc;
            COMMON_MODE_CODE <= next_vcm;
            HIGH_BATTERY_CODE <= next_hbat;
            LOW_BATTERY_CODE <= next_lbat;
            TRANSISTOR_POWER_POINTER <= next_ptr;
        end
    end

    // Read word assembly from the live field flops
    always @* begin
        rd_word = 32'h00000000;
        rd_known = 1'b1;
        case (ARADDR[11:2])
            `LSR_IDX_FEED: begin
                rd_word[`LSR_FEED_MSB:0] = FEED_CURRENT_CODE;
            end
            `LSR_IDX_ONHOOK: begin
                rd_word[`LSR_POL_BIT] = ONHOOK_POLARITY_SEL;
                rd_word[`LSR_CODE_MSB:0] = ONHOOK_VOLTAGE_CODE;
            end
            `LSR_IDX_CMODE: begin
                rd_word[`LSR_CODE_MSB:0] = COMMON_MODE_CODE;
            end
            `LSR_IDX_HBAT: begin
                rd_word[`LSR_CODE_MSB:0] = HIGH_BATTERY_CODE;
            end
            `LSR_IDX_LBAT: begin
                rd_word[`LSR_CODE_MSB:0] = LOW_BATTERY_CODE;
            end
            `LSR_IDX_PTR: begin
                rd_word[`LSR_PTR_MSB:0] = TRANSISTOR_POWER_POINTER;
            end
            `LSR_IDX_PWR: begin
                rd_word[`LSR_PWR_MSB:0] = power_reading;
            end
            // Unknown indices answer with an error and zero data
            default: begin
                rd_known = 1'b0;
            end
        endcase
    end

    // Read address channel; one read is in flight at a time,
    // so the next address waits for the data handshake
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ARREADY <= 1'b0;
        end else begin
            if (!started) begin
                ARREADY <= 1'b1;
            end
            if (ARVALID && ARREADY) begin
                ARREADY <= 1'b0;
            end
            if (RVALID && RREADY) begin
                ARREADY <= 1'b1;
            end
        end
    end

    // Read data is captured at the address handshake, so a field written
    // while the answer waits does not alter it
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= `LSR_RESP_OKAY;
        end else begin
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RDATA <= rd_word;
                RRESP <= rd_known ? `LSR_RESP_OKAY : `LSR_RESP_SLVERR;
            end
            if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// [sim/lsr_setpoint_checker.sv]
// Port assertions for the setpoint register bank
`timescale 1ns/1ps
`default_nettype none
module lsr_setpoint_checker (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic AWREADY,
    input wire logic WREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [2:0] FEED_CURRENT_CODE,
    input wire logic ONHOOK_POLARITY_SEL,
    input wire logic [5:0] ONHOOK_VOLTAGE_CODE,
    input wire logic [5:0] COMMON_MODE_CODE,
    input wire logic [5:0] HIGH_BATTERY_CODE,
    input wire logic [5:0] LOW_BATTERY_CODE,
    input wire logic [2:0] TRANSISTOR_POWER_POINTER,
    input wire logic [7:0] TRANSISTOR_POWER_READING,
    input wire logic POWER_FINE_SCALE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    reset_codes_a: assert property ($fell(RST) |-> ONHOOK_VOLTAGE_CODE == 6'h20 &&
        HIGH_BATTERY_CODE == 6'h32 && LOW_BATTERY_CODE == 6'h10 && COMMON_MODE_CODE == 6'h02)
        else $error("codes not at reset values");
    write_refused_a: assert property ($rose(BVALID) |-> !AWREADY && !WREADY)
        else $error("write ready during response");
    write_done_a: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
        else $error("write response not closed");
    read_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read answer late");
    read_done_a: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
        else $error("read response not closed");
    reserved_zero_a: assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    // Codes may only move at the edge that raises the write response
    codes_hold_a: assert property (!$stable({FEED_CURRENT_CODE, ONHOOK_POLARITY_SEL,
        ONHOOK_VOLTAGE_CODE, COMMON_MODE_CODE, HIGH_BATTERY_CODE, LOW_BATTERY_CODE,
        TRANSISTOR_POWER_POINTER}) |-> $rose(BVALID)) else $error("code changed without write");
    fine_scale_a: assert property (##1 POWER_FINE_SCALE ==
        ($past(TRANSISTOR_POWER_POINTER) inside {3'h2, 3'h3})) else $error("wrong power scale");
    undef_ptr_a: assert property (TRANSISTOR_POWER_POINTER[2:1] == 2'b11
        |=> TRANSISTOR_POWER_READING == 8'h00) else $error("undefined pointer reading");
    cover property (BVALID && BRESP == 2'h2);
    cover property (POWER_FINE_SCALE);
    cover property (RVALID && RREADY);
endmodule
`default_nettype wire

// [sim/tb_linefeed_setpoint_registers.sv]
// Self-checking bench for the setpoint register bank
`timescale 1ns/1ps
`default_nettype none
module tb_linefeed_setpoint_registers;
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'h0;
    logic [47:0] TRANSISTOR_POWER_IN = 48'h0;
    wire AWREADY, WREADY, BVALID, ARREADY, RVALID, ONHOOK_POLARITY_SEL, POWER_FINE_SCALE;
    wire [1:0] BRESP, RRESP;
    wire [31:0] RDATA;
    wire [2:0] FEED_CURRENT_CODE, TRANSISTOR_POWER_POINTER;
    wire [5:0] ONHOOK_VOLTAGE_CODE, COMMON_MODE_CODE, HIGH_BATTERY_CODE, LOW_BATTERY_CODE;
    wire [7:0] TRANSISTOR_POWER_READING;
    int num_errors = 0;
    int checks = 0;
    integer seed = 32'h4AB8DCB4;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [7:0] mask[6] = '{8'h07, 8'h7F, 8'h3F, 8'h3F, 8'h3F, 8'h07};
    logic [7:0] shadow[6] = '{8'h00, 8'h20, 8'h02, 8'h32, 8'h10, 8'h00};
    logic [31:0] d;
    logic [47:0] pw;
    logic [7:0] pv;

    lsr_setpoint_regs dut (.SYS_CLK(SYS_CLK), .RST(RST), .AWADDR(AWADDR), .AWPROT(3'h0),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .TRANSISTOR_POWER_IN(TRANSISTOR_POWER_IN),
        .FEED_CURRENT_CODE(FEED_CURRENT_CODE), .ONHOOK_POLARITY_SEL(ONHOOK_POLARITY_SEL),
        .ONHOOK_VOLTAGE_CODE(ONHOOK_VOLTAGE_CODE), .COMMON_MODE_CODE(COMMON_MODE_CODE),
        .HIGH_BATTERY_CODE(HIGH_BATTERY_CODE), .LOW_BATTERY_CODE(LOW_BATTERY_CODE),
        .TRANSISTOR_POWER_POINTER(TRANSISTOR_POWER_POINTER),
        .TRANSISTOR_POWER_READING(TRANSISTOR_POWER_READING), .POWER_FINE_SCALE(POWER_FINE_SCALE));

    always #2.5 SYS_CLK = ~SYS_CLK;

    task check(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Results are compared at the edge where the response is taken
    always @(posedge SYS_CLK) begin
        if (RVALID === 1'b1 && RREADY) check({RRESP, RDATA}, rq.pop_front());
        if (BVALID === 1'b1 && BREADY) check(34'(BRESP), 34'(bq.pop_front()));
    end

    function logic [11:0] ra(input int i);
        return 12'h11C + 12'(i * 4);
    endfunction

    task wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] e);
        logic aw, w;
        bq.push_back(e);
        AWADDR <= a;
        WDATA <= v;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        aw = 1'b0;
        w = 1'b0;
        while (!(aw && w)) begin
            @(posedge SYS_CLK);
            if (!aw && AWREADY === 1'b1) begin
                aw = 1'b1;
                AWVALID <= 1'b0;
            end
            if (!w && WREADY === 1'b1) begin
                w = 1'b1;
                WVALID <= 1'b0;
            end
        end
        do @(posedge SYS_CLK); while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    task rd(input logic [11:0] a, input logic [33:0] e);
        rq.push_back(e);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge SYS_CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge SYS_CLK); while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    task rd_all;
        for (int i = 0; i < 6; i++) rd(ra(i), {26'h0, shadow[i]});
        check(34'({FEED_CURRENT_CODE, ONHOOK_POLARITY_SEL, ONHOOK_VOLTAGE_CODE, COMMON_MODE_CODE,
            HIGH_BATTERY_CODE, LOW_BATTERY_CODE, TRANSISTOR_POWER_POINTER}),
            34'({shadow[0][2:0], shadow[1][6:0], shadow[2][5:0], shadow[3][5:0],
            shadow[4][5:0], shadow[5][2:0]}));
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100us;
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge SYS_CLK);
        RST <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        rd_all();
        $display("reset values done");
        // Random data sets reserved bits, which must not stick
        repeat (3) begin
            for (int i = 0; i < 6; i++) begin
                d = $random(seed);
                if (i == 3) d[5] = 1'b1;
                if (i == 4) d[5] = 1'b0;
                wr(ra(i), d, 4'hF, 2'h0);
                shadow[i] = d[7:0] & mask[i];
            end
            rd_all();
        end
        $display("random writes done");
        wr(ra(0), 32'h7, 4'hE, 2'h0);
        wr(12'h134, 32'hFF, 4'hF, 2'h2);
        wr(12'h138, 32'hFF, 4'hF, 2'h2);
        rd(12'h138, {2'h2, 32'h0});
        rd(12'h118, {2'h2, 32'h0});
        rd_all();
        $display("refusals done");
        pw = {16'($random(seed)), $random(seed)};
        TRANSISTOR_POWER_IN <= pw;
        for (int p = 0; p < 8; p++) begin
            wr(ra(5), 32'(p), 4'hF, 2'h0);
            shadow[5] = 8'(p);
            repeat (4) @(posedge SYS_CLK);
            pv = (p < 6) ? pw[8 * p +: 8] : 8'h00;
            check(34'({POWER_FINE_SCALE, TRANSISTOR_POWER_READING}),
                34'({(p == 2) || (p == 3), pv}));
            rd(12'h134, {26'h0, pv});
        end
        $display("power pointer done");
        RST <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        RST <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        shadow = '{8'h00, 8'h20, 8'h02, 8'h32, 8'h10, 8'h00};
        rd_all();
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule

bind lsr_setpoint_regs lsr_setpoint_checker chk (.SYS_CLK(SYS_CLK), .RST(RST),
    .AWREADY(AWREADY), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
    .FEED_CURRENT_CODE(FEED_CURRENT_CODE), .ONHOOK_POLARITY_SEL(ONHOOK_POLARITY_SEL),
    .ONHOOK_VOLTAGE_CODE(ONHOOK_VOLTAGE_CODE), .COMMON_MODE_CODE(COMMON_MODE_CODE),
    .HIGH_BATTERY_CODE(HIGH_BATTERY_CODE), .LOW_BATTERY_CODE(LOW_BATTERY_CODE),
    .TRANSISTOR_POWER_POINTER(TRANSISTOR_POWER_POINTER),
    .TRANSISTOR_POWER_READING(TRANSISTOR_POWER_READING), .POWER_FINE_SCALE(POWER_FINE_SCALE));
`default_nettype wire
